/* File: design/rlc_flash_end.sv */
// Flash side read latency selection: answers read and query requests, counts gap cycles.
`timescale 1ns/1ps
// What this block does
// - Code 01 selects the 90 MHz band.
// - Code 10 selects the 108 MHz band, or the 133 MHz band when fastBand is set.
// - 133 MHz band: only fast read, eight dummies.
// - FFh marks a read as unsupported.
// - Fast read: no mode, eight dummy cycles above 50 MHz.
// - Dual/quad out: no mode, eight dummies at 80 to 108 MHz.
// - 133 MHz band refuses dual and quad reads.
// - Dual I/O: four mode, dummies 0/1/2.
// - Quad I/O: two mode, dummies 4/4/5.
// - Pad parameter: F0h, length, FFh filler.
// - Code 00 is the 80 MHz reset default.
// - Code 11 is 50 MHz, simple reads need nothing.
module rlc_flash_end (
   rlc_link_if.dev link,
   input wire logic [1:0] latCode,
   input wire logic fastBand,
   output logic [1:0] activeCode,
   output logic busy
);
   import rlc_pkg::*;

   typedef enum logic [1:0] {
      DS_IDLE = 2'b01,
      DS_GAP  = 2'b10
   } rlc_dstate_type;

   rlc_dstate_type state_r, state_nxt;
   logic [7:0] gapCnt_r, gapCnt_nxt;
   logic [1:0] code_r, code_nxt;
   logic fast_r, fast_nxt;
   logic ackValid_r, ackValid_nxt;
   logic ackUnsup_r, ackUnsup_nxt;
   logic [7:0] ackMode_r, ackMode_nxt;
   logic [7:0] ackDummy_r, ackDummy_nxt;
   logic [7:0] ackData_r, ackData_nxt;
   logic dataGo_r, dataGo_nxt;
   rlc_band_type band;
   logic [7:0] selMode;
   logic [7:0] selDummy;

   ////////////////////////////////////////////////////////////////////////////
   // Query byte at an address of the map starting with the latency parameter.
   function automatic logic [7:0] queryByte(input logic [7:0] addr);
      logic [7:0] rel;
      logic [2:0] row;
      logic [3:0] col;
      rlc_read_type rt;
      rlc_band_type b;
      rel = 8'h00;
      row = 3'h0;
      col = 4'h0;
      rt = RD_NORMAL;
      b = BAND_50;
      queryByte = QRY_FILL;
      if (addr < QRY_ROW2) begin
         unique case (addr)
            8'h00: queryByte = QRY_LAT_ID;
            8'h01: queryByte = QRY_LAT_LEN;
            8'h02: queryByte = QRY_ROWS;
            8'h03: queryByte = QRY_ROW_LEN;
            8'h04: queryByte = QRY_HDR_F;
            8'h05: queryByte = QRY_HDR_C;
            8'h06: queryByte = 8'h03;
            8'h07: queryByte = 8'h13;
            8'h08: queryByte = 8'h0B;
            8'h09: queryByte = 8'h0C;
            8'h0A: queryByte = 8'h3B;
            8'h0B: queryByte = 8'h3C;
            8'h0C: queryByte = 8'h6B;
            8'h0D: queryByte = 8'h6C;
            8'h0E: queryByte = 8'hBB;
            8'h0F: queryByte = 8'hBC;
            8'h10: queryByte = 8'hEB;
            default: queryByte = 8'hEC;
         endcase
      end else if (addr < QRY_LAT_END) begin
         rel = 8'(addr - QRY_ROW2);
         row = 3'(rel / QRY_ROW_LEN);
         col = 4'(rel % QRY_ROW_LEN);
         b = rlc_band_type'(row);
         rt = rlc_read_type'(3'((col - 4'h2) >> 1));
         if (col == 4'h0) begin
            queryByte = (b == BAND_50) ? MHZ_50 : (b == BAND_80) ? MHZ_80 :
                        (b == BAND_90) ? MHZ_90 : (b == BAND_108) ? MHZ_108 : MHZ_133;
         end else if (col == 4'h1) begin
            queryByte = (b == BAND_50) ? 8'(LAT_CODE_50) : (b == BAND_80) ? 8'(LAT_CODE_80) :
                        (b == BAND_90) ? 8'(LAT_CODE_90) : 8'(LAT_CODE_108);
         end else if (col[0] == 1'b0) begin
            queryByte = modeCycles(rt, b);
         end else begin
            queryByte = dummyCycles(rt, b);
         end
      end else if (addr == QRY_LAT_END) begin
         queryByte = QRY_PAD_ID;
      end else if (addr == 8'(QRY_LAT_END + 8'h01)) begin
         queryByte = QRY_PAD_LEN;
      end
   endfunction : queryByte

   ////////////////////////////////////////////////////////////////////////////
   // Band lookup from the code held at the time of the request.
   // code to band
   assign band = bandOf(code_r, fast_r);
   assign selMode = modeCycles(link.reqType, band);
   assign selDummy = dummyCycles(link.reqType, band);

   ////////////////////////////////////////////////////////////////////////////
   // Next state. The code is only taken while idle, so a read in flight keeps its count.
   always_comb begin
      state_nxt = state_r;
      gapCnt_nxt = gapCnt_r;
      code_nxt = code_r;
      fast_nxt = fast_r;
      ackValid_nxt = 1'b0;
      ackUnsup_nxt = ackUnsup_r;
      ackMode_nxt = ackMode_r;
      ackDummy_nxt = ackDummy_r;
      ackData_nxt = ackData_r;
      dataGo_nxt = 1'b0;
      unique case (state_r)
         DS_IDLE: begin
            code_nxt = latCode;
            fast_nxt = fastBand;
            if (link.reqValid && link.reqQuery) begin
               ackValid_nxt = 1'b1;
               ackUnsup_nxt = 1'b0;
               ackData_nxt = queryByte(link.reqAddr);
            end else if (link.reqValid) begin
               ackValid_nxt = 1'b1;
               ackMode_nxt = selMode;
               ackDummy_nxt = selDummy;
               ackUnsup_nxt = (selMode == CYC_UNSUP) || (selDummy == CYC_UNSUP);
               if (!ackUnsup_nxt) begin
                  gapCnt_nxt = 8'(selMode + selDummy);
                  // Even an empty gap waits a cycle, so data never starts together with the answer.
                  state_nxt = DS_GAP;
               end
            end
         end
         DS_GAP: begin
            if (gapCnt_r == CYC_NONE) begin
               dataGo_nxt = 1'b1;
               state_nxt = DS_IDLE;
            end else if (link.gapPulse) begin
               gapCnt_nxt = 8'(gapCnt_r - CYC_ONE);
               if (gapCnt_r == CYC_ONE) begin
                  dataGo_nxt = 1'b1;
                  state_nxt = DS_IDLE;
               end
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers.
   always_ff @(posedge link.clk) begin
      if (!link.rstn) begin
         state_r <= DS_IDLE;
         gapCnt_r <= CYC_NONE;
         code_r <= LAT_CODE_RESET;
         fast_r <= 1'b0;
         ackValid_r <= 1'b0;
         ackUnsup_r <= 1'b0;
         ackMode_r <= CYC_NONE;
         ackDummy_r <= CYC_NONE;
         ackData_r <= CYC_NONE;
         dataGo_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         gapCnt_r <= gapCnt_nxt;
         code_r <= code_nxt;
         fast_r <= fast_nxt;
         ackValid_r <= ackValid_nxt;
         ackUnsup_r <= ackUnsup_nxt;
         ackMode_r <= ackMode_nxt;
         ackDummy_r <= ackDummy_nxt;
         ackData_r <= ackData_nxt;
         dataGo_r <= dataGo_nxt;
      end
   end

   // Link outputs come straight from the registers above.
   assign link.ackValid = ackValid_r;
   assign link.ackUnsup = ackUnsup_r;
   assign link.ackMode = ackMode_r;
   assign link.ackDummy = ackDummy_r;
   assign link.ackData = ackData_r;
   assign link.dataGo = dataGo_r;
   assign activeCode = code_r;
   assign busy = state_r[1];

endmodule : rlc_flash_end

/* File: design/rlc_host_end.sv */
// Host controller side: picks a latency code, issues reads and inserts the gap cycles.
`timescale 1ns/1ps
module rlc_host_end (
   rlc_link_if.host link,
   input wire logic [7:0] sckMhz,
   input wire logic start,
   input wire logic queryReq,
   input wire rlc_pkg::rlc_read_type rdType,
   input wire logic [7:0] qryAddr,
   output logic [1:0] codeSel,
   output logic fastSel,
   output logic done,
   output logic refused,
   output logic mismatch,
   output logic [7:0] qryByte
);
   import rlc_pkg::*;

   typedef enum logic [3:0] {
      HS_IDLE = 4'b0001,
      HS_WAIT = 4'b0010,
      HS_GAP  = 4'b0100,
      HS_DATA = 4'b1000
   } rlc_hstate_type;

   rlc_hstate_type state_r, state_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic [1:0] code_r, code_nxt;
   logic fast_r, fast_nxt;
   logic isQry_r, isQry_nxt;
   rlc_read_type type_r, type_nxt;
   logic reqValid_r, reqValid_nxt;
   logic [7:0] reqAddr_r, reqAddr_nxt;
   logic gapPulse_r, gapPulse_nxt;
   logic done_r, done_nxt;
   logic refused_r, refused_nxt;
   logic mismatch_r, mismatch_nxt;
   logic [7:0] qryByte_r, qryByte_nxt;
   rlc_band_type band;
   logic [7:0] expMode;
   logic [7:0] expDummy;

   ////////////////////////////////////////////////////////////////////////////
   // Code choice from the clock rate: lowest band whose ceiling covers it.
   always_comb begin
      if (sckMhz <= MHZ_50) begin
         code_nxt = LAT_CODE_50;
      end else if (sckMhz <= MHZ_80) begin
         code_nxt = LAT_CODE_80;
      end else if (sckMhz <= MHZ_90) begin
         code_nxt = LAT_CODE_90;
      end else begin
         code_nxt = LAT_CODE_108;
      end
      fast_nxt = sckMhz > MHZ_108;
   end

   assign band = bandOf(code_r, fast_r);
   assign expMode = modeCycles(rdType, band);
   assign expDummy = dummyCycles(rdType, band);

   ////////////////////////////////////////////////////////////////////////////
   // Request sequencing.
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      isQry_nxt = isQry_r;
      type_nxt = type_r;
      reqValid_nxt = 1'b0;
      reqAddr_nxt = reqAddr_r;
      gapPulse_nxt = 1'b0;
      done_nxt = 1'b0;
      refused_nxt = 1'b0;
      mismatch_nxt = mismatch_r;
      qryByte_nxt = qryByte_r;
      unique case (state_r)
         HS_IDLE: begin
            if (queryReq) begin
               isQry_nxt = 1'b1;
               reqAddr_nxt = qryAddr;
               reqValid_nxt = 1'b1;
               state_nxt = HS_WAIT;
            end else if (start) begin
               if (expMode == CYC_UNSUP || expDummy == CYC_UNSUP) begin
                  refused_nxt = 1'b1;
                  done_nxt = 1'b1;
               end else begin
                  isQry_nxt = 1'b0;
                  type_nxt = rdType;
                  cnt_nxt = 8'(expMode + expDummy);
                  reqValid_nxt = 1'b1;
                  state_nxt = HS_WAIT;
               end
            end
         end
         HS_WAIT: begin
            if (link.ackValid && isQry_r) begin
               qryByte_nxt = link.ackData;
               done_nxt = 1'b1;
               state_nxt = HS_IDLE;
            end else if (link.ackValid) begin
               mismatch_nxt = link.ackUnsup || (8'(link.ackMode + link.ackDummy) != cnt_r);
               if (link.ackUnsup) begin
                  refused_nxt = 1'b1;
                  done_nxt = 1'b1;
                  state_nxt = HS_IDLE;
               end else if (cnt_r == CYC_NONE) begin
                  state_nxt = HS_DATA;
               end else begin
                  state_nxt = HS_GAP;
               end
            end
         end
         HS_GAP: begin
            gapPulse_nxt = 1'b1;
            cnt_nxt = 8'(cnt_r - CYC_ONE);
            if (cnt_r == CYC_ONE) begin
               state_nxt = HS_DATA;
            end
         end
         HS_DATA: begin
            if (link.dataGo) begin
               done_nxt = 1'b1;
               state_nxt = HS_IDLE;
            end
         end
         default: state_nxt = HS_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers; the gap strobe is a flop so exactly cnt pulses reach the flash.
   always_ff @(posedge link.clk) begin
      if (!link.rstn) begin
         state_r <= HS_IDLE;
         cnt_r <= CYC_NONE;
         code_r <= LAT_CODE_RESET;
         fast_r <= 1'b0;
         isQry_r <= 1'b0;
         type_r <= RD_NORMAL;
         reqValid_r <= 1'b0;
         reqAddr_r <= CYC_NONE;
         gapPulse_r <= 1'b0;
         done_r <= 1'b0;
         refused_r <= 1'b0;
         mismatch_r <= 1'b0;
         qryByte_r <= CYC_NONE;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         code_r <= code_nxt;
         fast_r <= fast_nxt;
         isQry_r <= isQry_nxt;
         type_r <= type_nxt;
         reqValid_r <= reqValid_nxt;
         reqAddr_r <= reqAddr_nxt;
         gapPulse_r <= gapPulse_nxt;
         done_r <= done_nxt;
         refused_r <= refused_nxt;
         mismatch_r <= mismatch_nxt;
         qryByte_r <= qryByte_nxt;
      end
   end

   assign link.reqValid = reqValid_r;
   assign link.reqQuery = isQry_r;
   assign link.reqType = type_r;
   assign link.reqAddr = reqAddr_r;
   assign link.gapPulse = gapPulse_r;
   assign codeSel = code_r;
   assign fastSel = fast_r;
   assign done = done_r;
   assign refused = refused_r;
   assign mismatch = mismatch_r;
   assign qryByte = qryByte_r;

endmodule : rlc_host_end

/* File: design/rlc_link_if.sv */
// Link between the host controller end and the flash latency end.
`timescale 1ns/1ps
interface rlc_link_if (
   input wire logic clk,
   input wire logic rstn
);
   import rlc_pkg::*;

   logic reqValid;
   logic reqQuery;
   rlc_read_type reqType;
   logic [7:0] reqAddr;
   logic gapPulse;
   logic ackValid;
   logic ackUnsup;
   logic [7:0] ackMode;
   logic [7:0] ackDummy;
   logic [7:0] ackData;
   logic dataGo;

   modport host (
      input clk, rstn, ackValid, ackUnsup, ackMode, ackDummy, ackData, dataGo,
      output reqValid, reqQuery, reqType, reqAddr, gapPulse
   );

   modport dev (
      input clk, rstn, reqValid, reqQuery, reqType, reqAddr, gapPulse,
      output ackValid, ackUnsup, ackMode, ackDummy, ackData, dataGo
   );
endinterface : rlc_link_if

/* File: design/rlc_pkg.sv */
// Shared constants, types and latency table functions for the read latency blocks.
package rlc_pkg;

   // Read command families that carry a mode and latency figure.
   typedef enum logic [2:0] {
      RD_NORMAL   = 3'h0,
      RD_FAST     = 3'h1,
      RD_DUAL_OUT = 3'h2,
      RD_QUAD_OUT = 3'h3,
      RD_DUAL_IO  = 3'h4,
      RD_QUAD_IO  = 3'h5
   } rlc_read_type;

   // Frequency bands, in the order the query table lists them.
   typedef enum logic [2:0] {
      BAND_50  = 3'h0,
      BAND_80  = 3'h1,
      BAND_90  = 3'h2,
      BAND_108 = 3'h3,
      BAND_133 = 3'h4
   } rlc_band_type;

   localparam logic [1:0] LAT_CODE_80 = 2'h0;
   localparam logic [1:0] LAT_CODE_90 = 2'h1;
   localparam logic [1:0] LAT_CODE_108 = 2'h2;
   localparam logic [1:0] LAT_CODE_50 = 2'h3;
   localparam logic [1:0] LAT_CODE_RESET = LAT_CODE_80;

   localparam logic [7:0] MHZ_50 = 8'h32;
   localparam logic [7:0] MHZ_80 = 8'h50;
   localparam logic [7:0] MHZ_90 = 8'h5A;
   localparam logic [7:0] MHZ_108 = 8'h68;
   localparam logic [7:0] MHZ_133 = 8'h85;

   localparam logic [7:0] CYC_UNSUP = 8'hFF;
   localparam logic [7:0] CYC_NONE = 8'h00;
   localparam logic [7:0] CYC_ONE = 8'h01;
   localparam logic [7:0] CYC_TWO = 8'h02;
   localparam logic [7:0] CYC_FOUR = 8'h04;
   localparam logic [7:0] CYC_FIVE = 8'h05;
   localparam logic [7:0] CYC_EIGHT = 8'h08;

   // Query map layout: latency parameter, then one pad parameter.
   localparam logic [7:0] QRY_LAT_ID = 8'h90;
   localparam logic [7:0] QRY_LAT_END = 8'h58;
   localparam logic [7:0] QRY_LAT_LEN = 8'h56;
   localparam logic [7:0] QRY_ROWS = 8'h06;
   localparam logic [7:0] QRY_ROW_LEN = 8'h0E;
   localparam logic [7:0] QRY_HDR_F = 8'h46;
   localparam logic [7:0] QRY_HDR_C = 8'h43;
   localparam logic [7:0] QRY_ROW2 = 8'h12;
   localparam logic [7:0] QRY_PAD_ID = 8'hF0;
   localparam logic [7:0] QRY_PAD_LEN = 8'h0E;
   localparam logic [7:0] QRY_FILL = 8'hFF;

   // Band that a latency code selects; the fast flag picks the top band of code 10.
   function automatic rlc_band_type bandOf(input logic [1:0] code, input logic fastBand);
      unique case (code)
         LAT_CODE_50: bandOf = BAND_50;
         LAT_CODE_80: bandOf = BAND_80;
         LAT_CODE_90: bandOf = BAND_90;
         default: bandOf = fastBand ? BAND_133 : BAND_108;
      endcase
   endfunction : bandOf

   // Mode cycles of a read type in a band; all-ones means not supported.
   function automatic logic [7:0] modeCycles(input rlc_read_type rt, input rlc_band_type b);
      modeCycles = CYC_NONE;
      if (b == BAND_133 && rt != RD_FAST) begin
         modeCycles = CYC_UNSUP;
      end else if (rt == RD_NORMAL && b != BAND_50) begin
         modeCycles = CYC_UNSUP;
      end else if (rt == RD_DUAL_IO) begin
         modeCycles = CYC_FOUR;
      end else if (rt == RD_QUAD_IO) begin
         modeCycles = CYC_TWO;
      end
   endfunction : modeCycles

   // Dummy cycles of a read type in a band; all-ones means not supported.
   function automatic logic [7:0] dummyCycles(input rlc_read_type rt, input rlc_band_type b);
      dummyCycles = CYC_NONE;
      if (modeCycles(rt, b) == CYC_UNSUP) begin
         dummyCycles = CYC_UNSUP;
      end else if (rt == RD_DUAL_IO) begin
         dummyCycles = (b == BAND_90) ? CYC_ONE : (b == BAND_108) ? CYC_TWO : CYC_NONE;
      end else if (rt == RD_QUAD_IO) begin
         dummyCycles = (b == BAND_50) ? CYC_ONE : (b == BAND_108) ? CYC_FIVE : CYC_FOUR;
      end else if (b != BAND_50) begin
         dummyCycles = CYC_EIGHT;
      end
   endfunction : dummyCycles

endpackage : rlc_pkg

/* File: verif/rlc_link_monitor.sv */
// Concurrent checks on the latency link between the host end and the flash end.
`timescale 1ns/1ps
module rlc_link_monitor (
   input wire logic clk,
   input wire logic rstn,
   input wire logic reqValid,
   input wire logic reqQuery,
   input wire rlc_pkg::rlc_read_type reqType,
   input wire logic [7:0] reqAddr,
   input wire logic gapPulse,
   input wire logic ackValid,
   input wire logic ackUnsup,
   input wire logic [7:0] ackMode,
   input wire logic [7:0] ackDummy,
   input wire logic [7:0] ackData,
   input wire logic dataGo
);
   import rlc_pkg::*;
   logic [8:0] gapCnt_r;
   logic [8:0] gapCnt_nxt;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////
   // Gap pulses since the last answer; cleared by every answer so a short gap cannot borrow old pulses.
   always_comb begin
      gapCnt_nxt = gapCnt_r;
      if (ackValid) begin
         gapCnt_nxt = 9'h000;
      end else if (gapPulse) begin
         gapCnt_nxt = gapCnt_r + 9'h001;
      end
   end
   // Counter register.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         gapCnt_r <= 9'h000;
      end else begin
         gapCnt_r <= gapCnt_nxt;
      end
   end
   ////////////////////////////////////////////////////////////
   property p_ack_next; reqValid |=> ackValid; endproperty
   a_ack_next: assert property (p_ack_next) else $error("no answer after request");
   property p_unsup_ff; ackValid && ackUnsup |-> ackMode == 8'hFF && ackDummy == 8'hFF; endproperty
   a_unsup_ff: assert property (p_unsup_ff) else $error("refused read without all-ones counts");
   property p_unsup_quiet; ackValid && ackUnsup |=> (!dataGo && !gapPulse) [*4]; endproperty
   a_unsup_quiet: assert property (p_unsup_quiet) else $error("gap or data after refusal");
   property p_fast; reqValid && !reqQuery && reqType == RD_FAST |=>
      ackMode == 8'h00 && (ackDummy == 8'h08 || ackDummy == 8'h00); endproperty
   a_fast: assert property (p_fast) else $error("fast read counts wrong");
   property p_dual_io; reqValid && !reqQuery && reqType == RD_DUAL_IO |=>
      ackUnsup || (ackMode == 8'h04 && ackDummy <= 8'h02); endproperty
   a_dual_io: assert property (p_dual_io) else $error("dual io counts wrong");
   property p_quad_io; reqValid && !reqQuery && reqType == RD_QUAD_IO |=>
      ackUnsup || (ackMode == 8'h02 && ackDummy inside {8'h01, 8'h04, 8'h05}); endproperty
   a_quad_io: assert property (p_quad_io) else $error("quad io counts wrong");
   property p_gap_total; dataGo |-> gapCnt_r == ({1'b0, ackMode} + {1'b0, ackDummy}); endproperty
   a_gap_total: assert property (p_gap_total) else $error("data start after wrong gap length");
   property p_go_bound; reqValid && !reqQuery ##1 ackValid && !ackUnsup |-> ##[1:12] dataGo; endproperty
   a_go_bound: assert property (p_go_bound) else $error("data start missing");
   property p_pad; reqValid && reqQuery && reqAddr == 8'h58 |=> ackData == 8'hF0; endproperty
   a_pad: assert property (p_pad) else $error("pad id wrong");
   property p_fill; reqValid && reqQuery && reqAddr inside {[8'h5A:8'h67]} |=> ackData == 8'hFF; endproperty
   a_fill: assert property (p_fill) else $error("pad filler wrong");
endmodule : rlc_link_monitor

/* File: verif/tb.sv */
// Self-checking bench joining host and flash ends, plus a bench-driven second flash end.
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
   $display("unexpected t=%0t got %0h exp %0h", $time, got, exp); end end
module tb;
   import rlc_pkg::*;
   logic clk, rstn, start, queryReq, fastSel, done, refused, mismatch, busy, fastBand2, busy2, unsup, ovr;
   logic [7:0] sckMhz, qryAddr, qryByte, gotMode, gotDummy;
   logic [1:0] codeSel, activeCode, latCode2, activeCode2;
   logic [27:0] row;
   rlc_read_type rdType;
   int bad_count = 0, total_checks = 0, cycles = 0, gaps, acks, goes;
   // Rows: SCK MHz, read type, expected mode count, expected dummy count.
   localparam logic [27:0] ROWS [22] = '{28'h3200000, 28'h3210000, 28'h3240400, 28'h3250201, 28'h500FFFF,
      28'h5010008, 28'h5040400, 28'h5050204, 28'h5A0FFFF, 28'h5A20008, 28'h5A40401, 28'h5A50204, 28'h680FFFF,
      28'h6830008, 28'h6840402, 28'h6850205, 28'h8510008, 28'h850FFFF, 28'h852FFFF, 28'h853FFFF, 28'h854FFFF,
      28'h855FFFF};
   // Query rows: address, expected byte.
   localparam logic [15:0] QROWS [15] = '{16'h0090, 16'h0156, 16'h1232, 16'h1303, 16'h2E5A, 16'h2F01, 16'h3D02,
      16'h4905, 16'h4B02, 16'h4F08, 16'h57FF, 16'h58F0, 16'h590E, 16'h5AFF, 16'h67FF};
   rlc_link_if link (.clk(clk), .rstn(rstn));
   rlc_link_if link2 (.clk(clk), .rstn(rstn));
   rlc_host_end i_rlc_host_end (.link(link), .sckMhz(sckMhz), .start(start), .queryReq(queryReq),
      .rdType(rdType), .qryAddr(qryAddr), .codeSel(codeSel), .fastSel(fastSel), .done(done),
      .refused(refused), .mismatch(mismatch), .qryByte(qryByte));
   rlc_flash_end i_rlc_flash_end (.link(link), .latCode(ovr ? latCode2 : codeSel), .fastBand(fastSel),
      .activeCode(activeCode), .busy(busy));
   rlc_flash_end i_rlc_flash_end_b (.link(link2), .latCode(latCode2), .fastBand(fastBand2),
      .activeCode(activeCode2), .busy(busy2));
   rlc_link_monitor i_rlc_link_monitor (.clk(clk), .rstn(rstn), .reqValid(link.reqValid),
      .reqQuery(link.reqQuery), .reqType(link.reqType), .reqAddr(link.reqAddr), .gapPulse(link.gapPulse),
      .ackValid(link.ackValid), .ackUnsup(link.ackUnsup), .ackMode(link.ackMode), .ackDummy(link.ackDummy),
      .ackData(link.ackData), .dataGo(link.dataGo));
   ////////////////////////////////////////////////////////////
   // Clock and hang guard; the ceiling is several times the expected run.
   initial clk = 1'b0;
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         end_sim();
      end
   end
   // Expected code for an SCK rate: the slowest band whose ceiling covers it.
   function automatic logic [1:0] expCode(input logic [7:0] m);
      return (m <= 8'h32) ? 2'h3 : (m <= 8'h50) ? 2'h0 : (m <= 8'h5A) ? 2'h1 : 2'h2;
   endfunction : expCode
   // Issues one read or query at the host user side and tallies link traffic until done.
   task automatic run_op(input logic isQ, input logic [7:0] mhz, input logic [2:0] t, input logic [7:0] a);
      int n;
      n = 0;
      sckMhz = mhz;
      rdType = rlc_read_type'(t);
      qryAddr = a;
      repeat (3) @(negedge clk);
      queryReq = isQ;
      start = !isQ;
      @(negedge clk);
      queryReq = 1'b0;
      start = 1'b0;
      gaps = 0;
      acks = 0;
      goes = 0;
      while (done !== 1'b1 && n < 40) begin
         gaps += int'(link.gapPulse === 1'b1);
         goes += int'(link.dataGo === 1'b1);
         if (link.ackValid === 1'b1) begin
            acks++;
            gotMode = link.ackMode;
            gotDummy = link.ackDummy;
         end
         @(negedge clk);
         n++;
      end
      `CHK(done, 1'b1);
   endtask : run_op
   // Drives the second flash end directly, as a host that may break the rules would.
   task automatic far_read(input logic [1:0] c, input logic fb, input logic [2:0] t, input logic [7:0] m,
      input logic [7:0] d);
      int n;
      n = (m == 8'hFF) ? 3 : int'(m) + int'(d);
      latCode2 = c;
      fastBand2 = fb;
      link2.reqType = rlc_read_type'(t);
      repeat (2) @(negedge clk);
      `CHK(activeCode2, c);
      link2.reqValid = 1'b1;
      @(negedge clk);
      link2.reqValid = 1'b0;
      `CHK(link2.ackValid, 1'b1);
      `CHK(link2.ackUnsup, m == 8'hFF);
      `CHK(link2.ackMode, m);
      `CHK(link2.ackDummy, d);
      @(negedge clk);
      `CHK(link2.dataGo, n == 0);
      for (int i = 0; i < n; i++) begin
         link2.gapPulse = 1'b1;
         @(negedge clk);
         `CHK(link2.dataGo, m != 8'hFF && i == n - 1);
      end
      link2.gapPulse = 1'b0;
      @(negedge clk);
      `CHK(link2.dataGo, 1'b0);
   endtask : far_read
   // Prints the verdict and stops.
   task automatic end_sim();
      if (bad_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////
   // Main sequence: reset, table of reads, queries, far-end abuse, reset in mid-gap.
   initial begin
      {rstn, start, queryReq, fastBand2, latCode2, qryAddr, ovr} = '0;
      sckMhz = 8'h32;
      rdType = RD_NORMAL;
      {link2.reqValid, link2.reqQuery, link2.gapPulse, link2.reqAddr} = '0;
      link2.reqType = RD_NORMAL;
      repeat (8) @(negedge clk);
      `CHK(activeCode, 2'h0);
      `CHK(codeSel, 2'h0);
      rstn = 1'b1;
      for (int i = 0; i < 22; i++) begin
         row = ROWS[i];
         run_op(1'b0, row[27:20], row[18:16], 8'h00);
         unsup = (row[15:8] == 8'hFF);
         `CHK(codeSel, expCode(row[27:20]));
         `CHK(activeCode, expCode(row[27:20]));
         `CHK(fastSel, row[27:20] > 8'h68);
         `CHK(refused, unsup);
         `CHK(acks, unsup ? 0 : 1);
         `CHK(goes, unsup ? 0 : 1);
         if (!unsup) begin
            `CHK(mismatch, 1'b0);
            `CHK(gotMode, row[15:8]);
            `CHK(gotDummy, row[7:0]);
            `CHK(gaps, int'(row[15:8]) + int'(row[7:0]));
         end
      end
      for (int i = 0; i < 15; i++) begin
         run_op(1'b1, sckMhz, 3'h0, QROWS[i][15:8]);
         `CHK(qryByte, QROWS[i][7:0]);
      end
      far_read(2'h0, 1'b0, 3'h1, 8'h00, 8'h08);
      far_read(2'h1, 1'b0, 3'h0, 8'hFF, 8'hFF);
      far_read(2'h2, 1'b1, 3'h1, 8'h00, 8'h08);
      far_read(2'h2, 1'b1, 3'h3, 8'hFF, 8'hFF);
      far_read(2'h2, 1'b0, 3'h5, 8'h02, 8'h05);
      far_read(2'h1, 1'b0, 3'h4, 8'h04, 8'h01);
      far_read(2'h3, 1'b0, 3'h1, 8'h00, 8'h00);
      // Flash held at the 80 MHz code while the host runs at 50 MHz: the normal read is refused.
      ovr = 1'b1;
      latCode2 = 2'h0;
      run_op(1'b0, 8'h32, 3'h0, 8'h00);
      `CHK(activeCode, 2'h0);
      `CHK(refused, 1'b1);
      `CHK(mismatch, 1'b1);
      `CHK(acks, 1);
      `CHK(goes, 0);
      `CHK(gotMode, 8'hFF);
      ovr = 1'b0;
      sckMhz = 8'h50;
      rdType = RD_FAST;
      repeat (3) @(negedge clk);
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      repeat (5) @(negedge clk);
      `CHK(busy, 1'b1);
      sckMhz = 8'h85;
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      `CHK(busy, 1'b0);
      `CHK(activeCode, 2'h0);
      `CHK(codeSel, 2'h0);
      rstn = 1'b1;
      run_op(1'b0, 8'h85, 3'h1, 8'h00);
      `CHK(activeCode, 2'h2);
      `CHK(gaps, 8);
      end_sim();
   end
endmodule : tb
